/* File: src/pfs_status_bank.sv */
// Status flags and output voltage readback for the power stage.
// Assumes a bus decoder on ref_clk gives command, strobes and data.
// Notes on behaviour
// RQ1 - Status reads return one byte, unused zero
// RQ2 - Temperature fault and warning at limits
// RQ3 - Cleared temperature flags re-set until cooled
// RQ4 - Host write clears latched flags
// RQ5 - Each writable flag has alert mask
// RQ6 - Bad command bit7, bad data bit6
// RQ7 - PEC failure bit5, memory fault bit4
// RQ8 - Other communication fault sets bit1
// RQ9 - Die overheat bit7, clearable and maskable
// RQ10 - FSM zero state sets bit6, no alert
// RQ11 - FSM multi hot sets bit5, no alert
// RQ12 - Voltage selection detect failure bit4, alerts
// RQ13 - Loop master off on bad selection
// RQ14 - Soft-start detect failure bit3, no alert
// RQ15 - Detect flags cleared only by host; the follower role also forces them to zero
// RQ16 - Loop follower holds detect flags zero
// RQ17 - Reset pin low reports, restores boot voltage
// RQ18 - Bit1 shows loop follower role
// RQ19 - Bit0 live sync fault, no alert
// RQ20 - Voltage word linear, exponent minus nine
// RQ21 - Voltage taken from remote sense amplifier
// RQ22 - Reserved bits read zero, ignore writes
// RQ23 - Write one clears, zero keeps
`timescale 1ns/100ps
`default_nettype none

module pfs_status_bank #(
  parameter int FSM_WIDTH = 8
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [7:0]                     cmd_code,
  input  wire logic                           rd_strobe,
  input  wire logic                           wr_strobe,
  input  wire logic [7:0]                     wr_data,
  input  wire logic                           clear_faults,
  input  wire logic [7:0]                     temp_mask_nv,
  input  wire logic [7:0]                     comm_mask_nv,
  input  wire logic [7:0]                     vend_mask_nv,
  input  wire logic [pfs_pkg::TEMP_WIDTH-1:0] ext_temp,
  input  wire logic [pfs_pkg::TEMP_WIDTH-1:0] temp_fault_threshold,
  input  wire logic [pfs_pkg::TEMP_WIDTH-1:0] temp_warn_threshold,
  input  wire logic                           bad_cmd_evt,
  input  wire logic                           bad_data_evt,
  input  wire logic                           pec_fail_evt,
  input  wire logic                           mem_fault_evt,
  input  wire logic                           other_comm_evt,
  input  wire logic                           die_overheat_evt,
  input  wire logic [FSM_WIDTH-1:0]           op_fsm_state,
  input  wire logic                           boot_voltage_select_pin_reading_valid,
  input  wire logic [1:0]                     boot_voltage_select_pin_reading,
  input  wire logic                           ss_reading_valid,
  input  wire logic [1:0]                     ss_reading,
  input  wire logic                           detect_done,
  input  wire logic                           drive_on_bad_selection_option,
  input  wire logic                           startup_req,
  input  wire logic                           reset_powergood_pin,
  input  wire logic                           loop_follower_strap,
  input  wire logic                           sync_fault_live,
  input  wire logic [10:0]                    sense_amp_code,
  output var  logic [15:0]                    rd_data,
  output var  logic                           alert_req,
  output var  logic                           loop_master_en,
  output var  logic                           vout_to_boot
);
  import pfs_pkg::*;

  typedef struct packed {
    logic [7:0]  comm;
    logic [7:0]  vend;
    logic [15:0] rd_data;
    logic        alert;
    logic        master_en;
    logic        to_boot;
    logic [2:0]  boot_voltage_select_pin_cnt;
    logic [1:0]  boot_voltage_select_pin_last;
    logic [2:0]  ss_cnt;
    logic [1:0]  ss_last;
    logic [1:0]  rst_pin_sync;
    logic [1:0]  sync_pin_sync;
    logic [1:0]  follow_sync;
    logic [15:0] vout;
  } pfs_sb_state_t;

  pfs_sb_state_t cur_ff;
  pfs_sb_state_t nxt_cur;

  logic       wr_temp;
  logic       wr_comm;
  logic       wr_vend;
  logic       otf_flag;
  logic       temp_warn_flag;
  logic [7:0] temp_byte;
  logic [7:0] comm_clr;
  logic [7:0] vend_clr;
  logic       fsm_zero;
  logic       fsm_multi;
  logic       loop_follower_flag;

  assign wr_temp = wr_strobe && (cmd_code == CMD_TEMP_STATUS);
  assign wr_comm = wr_strobe && (cmd_code == CMD_COMM_STATUS);
  assign wr_vend = wr_strobe && (cmd_code == CMD_VEND_STATUS);

  // RQ23 only ones clear, RQ22 masks reserved bits
  assign comm_clr = (wr_comm ? (wr_data & COMM_WMASK) : 8'h00)
                    | (clear_faults ? COMM_WMASK : 8'h00);
  assign vend_clr = (wr_vend ? (wr_data & VEND_WMASK) : 8'h00)
                    | (clear_faults ? VEND_LATCHED : 8'h00);

  assign fsm_zero  = op_fsm_state == '0;
  assign fsm_multi = (op_fsm_state & (op_fsm_state - 1'b1)) != '0;
  assign loop_follower_flag = cur_ff.follow_sync[1];

  ///////////////////////////////////////////////////////////////////////////

  pfs_thermal_flag u_fault (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .temp      (ext_temp),
    .threshold (temp_fault_threshold),
    .clear     ((wr_temp && wr_data[TEMP_FAULT_BIT]) || clear_faults),
    .flag      (otf_flag)
  );

  pfs_thermal_flag u_warn (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .temp      (ext_temp),
    .threshold (temp_warn_threshold),
    .clear     ((wr_temp && wr_data[TEMP_WARN_BIT]) || clear_faults),
    .flag      (temp_warn_flag)
  );

  // RQ22 reserved temperature bits zero
  assign temp_byte = {otf_flag, temp_warn_flag, 6'h00};

  ///////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rst_pin_sync  = {cur_ff.rst_pin_sync[0], reset_powergood_pin};
    nxt_cur.sync_pin_sync = {cur_ff.sync_pin_sync[0], sync_fault_live};
    nxt_cur.follow_sync   = {cur_ff.follow_sync[0], loop_follower_strap};

    // RQ4 clear first so a same-cycle event wins
    nxt_cur.comm = cur_ff.comm & ~comm_clr;
    // RQ6 command and data faults
    if (bad_cmd_evt) nxt_cur.comm[COMM_BADCMD_BIT] = 1'b1;
    if (bad_data_evt) nxt_cur.comm[COMM_BADDATA_BIT] = 1'b1;
    // RQ7 PEC and memory faults
    if (pec_fail_evt) nxt_cur.comm[COMM_PEC_BIT] = 1'b1;
    if (mem_fault_evt) nxt_cur.comm[COMM_MEM_BIT] = 1'b1;
    // RQ8 other communication fault
    if (other_comm_evt) nxt_cur.comm[COMM_OTHER_BIT] = 1'b1;

    // RQ15 detect flags drop only on write, clear-faults or follower role
    nxt_cur.vend = cur_ff.vend & ~vend_clr;
    // RQ9 die overheat
    if (die_overheat_evt) nxt_cur.vend[VEND_DIE_HOT_BIT] = 1'b1;
    // RQ10 zero state
    if (fsm_zero) nxt_cur.vend[VEND_FSM_ZERO_BIT] = 1'b1;
    // RQ11 multi-hot state
    if (fsm_multi) nxt_cur.vend[VEND_FSM_MULTI_BIT] = 1'b1;

    // RQ12 voltage selection needs four matching readings
    if (boot_voltage_select_pin_reading_valid) begin
      if (boot_voltage_select_pin_reading == cur_ff.boot_voltage_select_pin_last && cur_ff.boot_voltage_select_pin_cnt != 3'h0) begin
        if (cur_ff.boot_voltage_select_pin_cnt != 3'(DETECT_TRIES)) begin
          nxt_cur.boot_voltage_select_pin_cnt = cur_ff.boot_voltage_select_pin_cnt + 3'h1;
        end
      end else begin
        nxt_cur.boot_voltage_select_pin_cnt = 3'h1;
      end
      nxt_cur.boot_voltage_select_pin_last = boot_voltage_select_pin_reading;
    end
    // RQ14 soft-start needs four matching readings
    if (ss_reading_valid) begin
      if (ss_reading == cur_ff.ss_last && cur_ff.ss_cnt != 3'h0) begin
        if (cur_ff.ss_cnt != 3'(DETECT_TRIES)) begin
          nxt_cur.ss_cnt = cur_ff.ss_cnt + 3'h1;
        end
      end else begin
        nxt_cur.ss_cnt = 3'h1;
      end
      nxt_cur.ss_last = ss_reading;
    end
    if (detect_done && cur_ff.boot_voltage_select_pin_cnt != 3'(DETECT_TRIES)) begin
      nxt_cur.vend[VEND_BOOT_VOLTAGE_SELECT_PIN_BIT] = 1'b1;
    end
    if (detect_done && cur_ff.ss_cnt != 3'(DETECT_TRIES)) begin
      nxt_cur.vend[VEND_SS_BIT] = 1'b1;
    end
    // RQ16 follower forces detect flags low
    if (loop_follower_flag) begin
      nxt_cur.vend[VEND_BOOT_VOLTAGE_SELECT_PIN_BIT] = 1'b0;
      nxt_cur.vend[VEND_SS_BIT]   = 1'b0;
    end

    // RQ17 reset pin low, RQ18 role, RQ19 live sync
    nxt_cur.vend[VEND_RESET_BIT]    = ~cur_ff.rst_pin_sync[1];
    nxt_cur.vend[VEND_FOLLOWER_BIT] = loop_follower_flag;
    nxt_cur.vend[VEND_SYNC_BIT]     = cur_ff.sync_pin_sync[1];
    nxt_cur.to_boot                 = ~cur_ff.rst_pin_sync[1];

    // RQ13 master held off on failed selection
    nxt_cur.master_en = startup_req && !loop_follower_flag
      && (!cur_ff.vend[VEND_BOOT_VOLTAGE_SELECT_PIN_BIT] || drive_on_bad_selection_option);

    // RQ20 RQ21 linear word from sense amplifier
    nxt_cur.vout = {VOUT_EXPONENT, sense_amp_code};

    // RQ5 masked alert, non-alerting bits excluded
    nxt_cur.alert = |(temp_byte & TEMP_WMASK & ~temp_mask_nv)
      || |(cur_ff.comm & ~comm_mask_nv)
      || |(cur_ff.vend & ~VEND_NO_ALERT & ~vend_mask_nv);

    // RQ1 status byte reads, upper byte zero, voltage read full word
    unique case (cmd_code)
      CMD_TEMP_STATUS: nxt_cur.rd_data = {8'h00, temp_byte};
      CMD_COMM_STATUS: nxt_cur.rd_data = {8'h00, cur_ff.comm};
      CMD_VEND_STATUS: nxt_cur.rd_data = {8'h00, cur_ff.vend};
      CMD_VOUT_READ:   nxt_cur.rd_data = cur_ff.vout;
      default:         nxt_cur.rd_data = 16'h0000;
    endcase
    if (!rd_strobe) nxt_cur.rd_data = cur_ff.rd_data;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '{comm: STATUS_RESET, vend: STATUS_RESET,
                  rd_data: 16'h0000, vout: VOUT_RESET,
                  rst_pin_sync: 2'h3, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rd_data        = cur_ff.rd_data;
  assign alert_req      = cur_ff.alert;
  assign loop_master_en = cur_ff.master_en;
  assign vout_to_boot   = cur_ff.to_boot;

  ///////////////////////////////////////////////////////////////////////////

  a_badcmd_sets: assert property ( // RQ6
    @(posedge ref_clk) disable iff (rst)
    bad_cmd_evt |=> cur_ff.comm[COMM_BADCMD_BIT])
    else $error("bad command flag missed");
  a_baddata_sets: assert property ( // RQ6
    @(posedge ref_clk) disable iff (rst)
    bad_data_evt |=> cur_ff.comm[COMM_BADDATA_BIT])
    else $error("bad data flag missed");
  a_pec_sets: assert property ( // RQ7
    @(posedge ref_clk) disable iff (rst)
    pec_fail_evt |=> cur_ff.comm[COMM_PEC_BIT])
    else $error("pec flag missed");
  a_mem_sets: assert property ( // RQ7
    @(posedge ref_clk) disable iff (rst)
    mem_fault_evt |=> cur_ff.comm[COMM_MEM_BIT])
    else $error("memory fault flag missed");
  a_other_sets: assert property ( // RQ8
    @(posedge ref_clk) disable iff (rst)
    other_comm_evt |=> cur_ff.comm[COMM_OTHER_BIT])
    else $error("other fault flag missed");
  a_die_sets: assert property ( // RQ9
    @(posedge ref_clk) disable iff (rst)
    die_overheat_evt |=> cur_ff.vend[VEND_DIE_HOT_BIT])
    else $error("die overheat flag missed");
  a_zero_state: assert property ( // RQ10
    @(posedge ref_clk) disable iff (rst)
    fsm_zero |=> cur_ff.vend[VEND_FSM_ZERO_BIT])
    else $error("zero state flag missed");
  a_multi_state: assert property ( // RQ11
    @(posedge ref_clk) disable iff (rst)
    fsm_multi |=> cur_ff.vend[VEND_FSM_MULTI_BIT])
    else $error("multi state flag missed");
  a_follower_zero: assert property ( // RQ16
    @(posedge ref_clk) disable iff (rst)
    loop_follower_flag
    |=> !cur_ff.vend[VEND_BOOT_VOLTAGE_SELECT_PIN_BIT] && !cur_ff.vend[VEND_SS_BIT])
    else $error("detect flag set on follower");
  a_role_bit: assert property ( // RQ18
    @(posedge ref_clk) disable iff (rst)
    loop_follower_flag |=> cur_ff.vend[VEND_FOLLOWER_BIT])
    else $error("follower role bit missed");
  a_master_held: assert property ( // RQ13
    @(posedge ref_clk) disable iff (rst)
    cur_ff.vend[VEND_BOOT_VOLTAGE_SELECT_PIN_BIT] && !drive_on_bad_selection_option
    |=> !loop_master_en)
    else $error("master enabled after bad selection");
  a_reserved_zero: assert property ( // RQ22
    @(posedge ref_clk) disable iff (rst)
    $rose(rd_strobe) && cmd_code == CMD_COMM_STATUS
    |=> rd_data[15:8] == 8'h00 && rd_data[3:2] == 2'h0
        && !rd_data[0])
    else $error("reserved bits read nonzero");
  a_vout_exp: assert property ( // RQ20
    @(posedge ref_clk) disable iff (rst)
    rd_strobe && cmd_code == CMD_VOUT_READ
    |=> rd_data[15:11] == VOUT_EXPONENT)
    else $error("voltage exponent wrong");
  a_keep_zero: assert property ( // RQ23
    @(posedge ref_clk) disable iff (rst)
    cur_ff.comm[COMM_MEM_BIT] && wr_comm && !wr_data[COMM_MEM_BIT]
    && !clear_faults |=> cur_ff.comm[COMM_MEM_BIT])
    else $error("zero write cleared flag");

endmodule : pfs_status_bank

`default_nettype wire

/* File: pkg/pfs_pkg.sv */
// Constants for the status and telemetry register bank.
// Assumes a command decoder outside presents read and write strobes.
package pfs_pkg;

  localparam logic [7:0] CMD_TEMP_STATUS = 8'h7D;
  localparam logic [7:0] CMD_COMM_STATUS = 8'h7E;
  localparam logic [7:0] CMD_VEND_STATUS = 8'h80;
  localparam logic [7:0] CMD_VOUT_READ   = 8'h8B;

  localparam int TEMP_FAULT_BIT = 7;
  localparam int TEMP_WARN_BIT  = 6;
  localparam logic [7:0] TEMP_WMASK = 8'hC0;

  localparam int COMM_BADCMD_BIT  = 7;
  localparam int COMM_BADDATA_BIT = 6;
  localparam int COMM_PEC_BIT     = 5;
  localparam int COMM_MEM_BIT     = 4;
  localparam int COMM_OTHER_BIT   = 1;
  localparam logic [7:0] COMM_WMASK = 8'hF2;

  localparam int VEND_DIE_HOT_BIT   = 7;
  localparam int VEND_FSM_ZERO_BIT  = 6;
  localparam int VEND_FSM_MULTI_BIT = 5;
  localparam int VEND_BOOT_VOLTAGE_SELECT_PIN_BIT      = 4;
  localparam int VEND_SS_BIT        = 3;
  localparam int VEND_RESET_BIT     = 2;
  localparam int VEND_FOLLOWER_BIT  = 1;
  localparam int VEND_SYNC_BIT      = 0;
  localparam logic [7:0] VEND_WMASK   = 8'h98;
  localparam logic [7:0] VEND_LATCHED = 8'hF8;
  // Flags that never reach the alert line
  localparam logic [7:0] VEND_NO_ALERT = 8'h6F;

  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] VOUT_RESET   = 16'h0000;
  localparam logic [4:0]  VOUT_EXPONENT = 5'h17;
  localparam int          TEMP_WIDTH    = 11;
  localparam logic [10:0] TEMP_HYST     = 11'h014;
  localparam int          DETECT_TRIES  = 4;

endpackage : pfs_pkg

/* File: src/pfs_thermal_flag.sv */
// One latched temperature flag with re-set hysteresis.
// Assumes temperature and threshold on the same clock, in degrees.
`timescale 1ns/100ps
`default_nettype none

module pfs_thermal_flag (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [pfs_pkg::TEMP_WIDTH-1:0] temp,
  input  wire logic [pfs_pkg::TEMP_WIDTH-1:0] threshold,
  input  wire logic                           clear,
  output var  logic                           flag
);
  import pfs_pkg::*;

  typedef struct packed {
    logic flag;
    logic armed;
  } pfs_tf_state_t;

  pfs_tf_state_t cur_ff;
  pfs_tf_state_t nxt_cur;
  logic          at_limit;
  logic          cooled;

  assign at_limit = temp >= threshold;
  assign cooled   = ({1'b0, temp} + {1'b0, TEMP_HYST}) <= {1'b0, threshold};

  always_comb begin
    nxt_cur = cur_ff;
    // RQ3 re-set until cooled
    if (cooled) begin
      nxt_cur.armed = 1'b0;
    end else if (cur_ff.flag) begin
      nxt_cur.armed = 1'b1;
    end
    // RQ4 write-one clear
    if (clear) begin
      nxt_cur.flag = 1'b0;
    end
    // RQ2 set at or above limit, set wins
    if (at_limit || (cur_ff.armed && !cooled && !clear)) begin
      nxt_cur.flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign flag = cur_ff.flag;

  a_limit_sets: assert property ( // RQ2
    @(posedge ref_clk) disable iff (rst)
    at_limit |=> flag)
    else $error("flag not set at limit");

endmodule : pfs_thermal_flag

`default_nettype wire

/* File: dv/pfs_host_model.sv */
// Host side of the register access: read, write and clear-all strobes.
// Assumes the bank samples strobes on the rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none

module pfs_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] rd_data,
  output var  logic [7:0]  cmd_code,
  output var  logic        rd_strobe,
  output var  logic        wr_strobe,
  output var  logic [7:0]  wr_data,
  output var  logic        clear_faults
);
  initial begin
    cmd_code = 8'h00;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    wr_data = 8'h00;
    clear_faults = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe held over one edge, data taken after it
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    cmd_code = c;
    rd_strobe = 1'b1;
    @(posedge ref_clk);
    #1;
    rd_strobe = 1'b0;
    d = rd_data;
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    cmd_code = c;
    wr_data = v;
    wr_strobe = 1'b1;
    @(posedge ref_clk);
    #1;
    wr_strobe = 1'b0;
    wr_data = ~v;
  endtask : wr

  task automatic clr();
    @(posedge ref_clk);
    #1;
    clear_faults = 1'b1;
    @(posedge ref_clk);
    #1;
    clear_faults = 1'b0;
  endtask : clr
endmodule : pfs_host_model

`default_nettype wire

/* File: dv/pfs_status_bank_tb_top.sv */
// Self-checking bench for the status bank, host model drives the bus.
// Assumes 100 MHz ref_clk and inputs changed 1 ns after each edge.
`timescale 1ns/100ps
`default_nettype none

module pfs_status_bank_tb_top;
  import pfs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cmd_code, wr_data;
  logic        rd_strobe, wr_strobe, clear_faults;
  logic [7:0]  tmask = 8'h00, cmask = 8'h00, vmask = 8'h00, fsm = 8'h01;
  logic [4:0]  cev = 5'h00;
  logic        die = 0, vv = 0, sv = 0, done = 0, opt = 0, start = 0;
  logic        rpin = 1, fol = 0, sync = 0;
  logic [1:0]  vr = 2'h0, sr = 2'h0;
  logic [10:0] temp = 11'h000, sense = 11'h123;
  logic [10:0] flim = 11'h064, wlim = 11'h050;
  logic [15:0] rd_data, d;
  logic        alert_req, loop_master_en, vout_to_boot;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  int          cb[5] = '{7, 6, 5, 4, 1};

  always #5 ref_clk = ~ref_clk;

  pfs_host_model i_host (.ref_clk, .rd_data, .cmd_code, .rd_strobe,
    .wr_strobe, .wr_data, .clear_faults);

  pfs_status_bank #(.FSM_WIDTH(8)) i_pfs_status_bank (
    .ref_clk, .rst, .cmd_code, .rd_strobe, .wr_strobe, .wr_data,
    .clear_faults, .temp_mask_nv(tmask), .comm_mask_nv(cmask),
    .vend_mask_nv(vmask), .ext_temp(temp), .temp_fault_threshold(flim),
    .temp_warn_threshold(wlim), .bad_cmd_evt(cev[4]),
    .bad_data_evt(cev[3]), .pec_fail_evt(cev[2]), .mem_fault_evt(cev[1]),
    .other_comm_evt(cev[0]), .die_overheat_evt(die), .op_fsm_state(fsm),
    .boot_voltage_select_pin_reading_valid(vv), .boot_voltage_select_pin_reading(vr), .ss_reading_valid(sv),
    .ss_reading(sr), .detect_done(done),
    .drive_on_bad_selection_option(opt), .startup_req(start),
    .reset_powergood_pin(rpin), .loop_follower_strap(fol),
    .sync_fault_live(sync), .sense_amp_code(sense), .rd_data, .alert_req,
    .loop_master_en, .vout_to_boot);

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    i_host.rd(c, d);
    check("rd_data", d, exp);
  endtask : rchk

  task automatic do_reset();
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
  endtask : do_reset

  // Four detection samples, alternating or steady per lane
  task automatic detect(input logic valt, input logic salt);
    vv = 1;
    sv = 1;
    for (int i = 0; i < DETECT_TRIES; i++) begin
      vr = valt ? 2'(i & 1) : 2'h2;
      sr = salt ? 2'(i & 1) : 2'h2;
      tick(1);
    end
    vv = 0;
    sv = 0;
    done = 1;
    tick(1);
    done = 0;
  endtask : detect

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rchk(CMD_TEMP_STATUS, 16'h0000);
    rchk(CMD_COMM_STATUS, 16'h0000);
    rchk(CMD_VEND_STATUS, 16'h0000);
    rchk(8'h55, 16'h0000);
    rchk(CMD_VOUT_READ, {VOUT_EXPONENT, 11'h123});
    sense = 11'h7FE;
    rchk(CMD_VOUT_READ, {VOUT_EXPONENT, 11'h7FE});
    for (int i = 0; i < 5; i++) begin
      cev[4-i] = 1;
      tick(1);
      cev = 5'h00;
      rchk(CMD_COMM_STATUS, 16'(1 << cb[i]));
      check("alert_req", alert_req, 16'h1);
      i_host.wr(CMD_COMM_STATUS, 8'h00);
      rchk(CMD_COMM_STATUS, 16'(1 << cb[i]));
      i_host.wr(CMD_COMM_STATUS, 8'(1 << cb[i]) | 8'h0D);
      rchk(CMD_COMM_STATUS, 16'h0000);
      check("alert_req", alert_req, 16'h0);
    end
    cmask = 8'h80;
    cev[4] = 1;
    tick(1);
    cev = 5'h00;
    rchk(CMD_COMM_STATUS, 16'h0080);
    check("alert_req", alert_req, 16'h0);
    i_host.clr();
    cmask = 8'h00;
    temp = 11'd90;
    rchk(CMD_TEMP_STATUS, 16'h0040);
    temp = 11'd100;
    rchk(CMD_TEMP_STATUS, 16'h00C0);
    check("alert_req", alert_req, 16'h1);
    temp = 11'd85;
    i_host.wr(CMD_TEMP_STATUS, 8'hC0);
    rchk(CMD_TEMP_STATUS, 16'h00C0);
    temp = 11'd80;
    i_host.wr(CMD_TEMP_STATUS, 8'hFF);
    rchk(CMD_TEMP_STATUS, 16'h0040);
    tmask = 8'hC0;
    tick(2);
    check("alert_req", alert_req, 16'h0);
    tmask = 8'h00;
    temp = 11'd60;
    i_host.wr(CMD_TEMP_STATUS, 8'h40);
    rchk(CMD_TEMP_STATUS, 16'h0000);
    die = 1;
    tick(1);
    die = 0;
    rchk(CMD_VEND_STATUS, 16'h0080);
    check("alert_req", alert_req, 16'h1);
    vmask = 8'h80;
    tick(2);
    check("alert_req", alert_req, 16'h0);
    vmask = 8'h00;
    i_host.wr(CMD_VEND_STATUS, 8'h80);
    fsm = 8'h00;
    tick(1);
    fsm = 8'h01;
    rchk(CMD_VEND_STATUS, 16'h0040);
    fsm = 8'h03;
    tick(1);
    fsm = 8'h01;
    i_host.wr(CMD_VEND_STATUS, 8'h60);
    rchk(CMD_VEND_STATUS, 16'h0060);
    check("alert_req", alert_req, 16'h0);
    i_host.clr();
    rpin = 0;
    sync = 1;
    tick(4);
    rchk(CMD_VEND_STATUS, 16'h0005);
    check("vout_to_boot", vout_to_boot, 16'h1);
    check("alert_req", alert_req, 16'h0);
    rpin = 1;
    sync = 0;
    tick(4);
    rchk(CMD_VEND_STATUS, 16'h0000);
    check("vout_to_boot", vout_to_boot, 16'h0);
    detect(1'b1, 1'b0);
    start = 1;
    rchk(CMD_VEND_STATUS, 16'h0010);
    check("alert_req", alert_req, 16'h1);
    check("loop_master_en", loop_master_en, 16'h0);
    opt = 1;
    tick(2);
    check("loop_master_en", loop_master_en, 16'h1);
    start = 0;
    tick(2);
    start = 1;
    rchk(CMD_VEND_STATUS, 16'h0010);
    i_host.wr(CMD_VEND_STATUS, 8'h10);
    rchk(CMD_VEND_STATUS, 16'h0000);
    do_reset();
    detect(1'b0, 1'b1);
    rchk(CMD_VEND_STATUS, 16'h0008);
    check("alert_req", alert_req, 16'h0);
    fol = 1;
    do_reset();
    tick(3);
    detect(1'b1, 1'b1);
    rchk(CMD_VEND_STATUS, 16'h0002);
    check("loop_master_en", loop_master_en, 16'h0);
    print_verdict();
  end
endmodule : pfs_status_bank_tb_top

`default_nettype wire
